//--- rtl/mbt_ctrl.sv
// Summary of operation
// - Decode three-bit test configuration into eight modes
// - Config six resets engine, captures instruction
// - Instruction keeps value from last load edge
// - Instruction splits into control, block, data, pattern
// - Control zero runs test to completion
// - Control one halts shortly after miscompare
// - Control all-ones starts native code execution
// - Block field selects cache or MMU array
// - Data field gives root word or upload style
// - Scan output carries download data or status
// - Override acts after power manager stage
// - Output hold safe freezes core outputs in internal test
// - Reset safe holds debug domain reset in external test
// - External test keeps core reset; scan controls
// - Isolate selects short shared wrapper chain
// - Pattern field selects solids, checkerboard, march, bang
`timescale 1ns/1ps

module mbt_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // Fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // Drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       rd;
        logic [AW-1:0]       wr;
        logic [AW:0]         cnt;
        logic                rdy;
    } mbt_fifo_type;

    mbt_fifo_type r;
    mbt_fifo_type r_nxt;
    logic         push;
    logic         pop;

    function automatic logic [AW-1:0] f_inc(input logic [AW-1:0] p);
        f_inc = (p == AW'(D - 1)) ? '0 : p + 1'b1;
    endfunction

    assign push      = in_valid && r.rdy;
    assign pop       = out_ready && (r.cnt != '0);
    assign in_ready  = r.rdy;
    assign out_valid = (r.cnt != '0);
    assign out_data  = r.mem[r.rd];

    always_comb begin
        r_nxt = r;
        if (push) begin
            r_nxt.mem[r.wr] = in_data;
            r_nxt.wr        = f_inc(r.wr);
        end
        if (pop) begin
            r_nxt.rd = f_inc(r.rd);
        end
        r_nxt.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        r_nxt.rdy = (r_nxt.cnt < (AW+1)'(D));
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r     <= '0;
            r.rdy <= 1'b1;
        end else begin
            r <= r_nxt;
        end
    end
endmodule

module mbt_ctrl #(
    parameter int DL_DEPTH = 4
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // Tester port
    input  wire logic [2:0]  test_config_select,
    input  wire logic [15:0] scan_input_bus,
    output logic [15:0]      scan_output_bus,
    // Test reset and wrapper pins
    input  wire logic        scan_mode_select,
    input  wire logic        test_reset_override,
    input  wire logic        bus_reset_n,
    input  wire logic        soft_reset_n,
    input  wire logic        external_test_mode,
    input  wire logic        internal_test_mode,
    input  wire logic        output_hold_safe,
    input  wire logic        debug_domain_reset_safe,
    input  wire logic        user_logic_wrapper_isolate,
    // Core reset and wrapper controls
    output logic             core_bus_reset_n,
    output logic             core_soft_reset_n,
    output logic             debug_domain_reset,
    output logic             core_output_freeze,
    output logic             wrapper_short_chain,
    // Array access
    output logic             array_req,
    output logic             array_we,
    output logic [3:0]       array_block,
    output logic [10:0]      array_addr,
    output logic [15:0]      array_wdata,
    input  wire logic [15:0] array_rdata,
    // Cache upload
    output logic             upload_we,
    output logic [1:0]       upload_target,
    output logic             upload_cam,
    output logic [15:0]      upload_data,
    // Cache download
    input  wire logic        dl_valid,
    input  wire logic [15:0] dl_data,
    output logic             dl_ready,
    // Engine status
    output logic             bist_busy,
    output logic             bist_done,
    output logic             bist_error,
    output logic             native_exec
);
    mbt_pkg::mbt_ctrl_type r;
    mbt_pkg::mbt_ctrl_type r_nxt;
    logic                  fifo_valid;
    logic [15:0]           fifo_data;
    logic                  fifo_pop;
    logic [2:0]            cfg;
    logic [3:0]            ctl;
    logic [3:0]            blk;
    logic [3:0]            pat;

    // Number of passes per pattern, zero when reserved
    function automatic logic [4:0] f_npass(input logic [3:0] p);
        case (p)
            `MBT_PAT_WSOL, `MBT_PAT_RSOL,
            `MBT_PAT_WCKB, `MBT_PAT_RCKB: f_npass = `MBT_N_ONE;
            `MBT_PAT_ROWM, `MBT_PAT_COLM: f_npass = `MBT_N_MARCH;
            `MBT_PAT_BANG18:              f_npass = `MBT_N_BANG18;
            `MBT_PAT_BANG2:               f_npass = `MBT_N_BANG2;
            default:                      f_npass = 5'h00;
        endcase
    endfunction

    // Access kind of one pass
    function automatic mbt_pkg::mbt_step_type f_step(input logic [3:0] p,
                                                     input logic [4:0] n);
        mbt_pkg::mbt_step_type s;
        s = '0;
        case (p)
            `MBT_PAT_WSOL, `MBT_PAT_WCKB: s.wr = 1'b1;
            `MBT_PAT_ROWM, `MBT_PAT_COLM: begin
                s.wr  = ~n[0];
                s.inv = (n == 5'h02) || (n == 5'h03);
                s.dec = (n == 5'h03) || (n == 5'h04);
            end
            `MBT_PAT_BANG18, `MBT_PAT_BANG2: s.wr = ~n[0];
            default: s = '0;
        endcase
        f_step = s;
    endfunction

    function automatic logic f_blk_ok(input logic [3:0] b);
        f_blk_ok = (b[2] == 1'b0) && (b[1:0] != 2'h3);
    endfunction

    assign cfg = r.sync2[`MBT_PIN_CFG];
    assign ctl = r.instr[`MBT_CTL_RNG];
    assign blk = r.instr[`MBT_BLK_RNG];
    assign pat = r.instr[`MBT_PAT_RNG];
    assign fifo_pop = (cfg == `MBT_CFG_ICDL) || (cfg == `MBT_CFG_DCDL) ||
                      (cfg == `MBT_CFG_CAMDL);

    mbt_fifo #(
        .W (16),
        .D (DL_DEPTH)
    ) u_dl_fifo (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (dl_valid),
        .in_data   (dl_data),
        .in_ready  (dl_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (fifo_pop)
    );

    always_comb begin
        mbt_pkg::mbt_step_type s;
        logic [10:0] lim;
        logic [10:0] idx;
        logic [5:0]  x;
        logic [4:0]  y;
        logic [15:0] d;
        logic [4:0]  np;
        s     = f_step(pat, r.pass);
        np    = f_npass(pat);
        lim   = blk[`MBT_BLK_MMU] ? `MBT_LIM_MMU : `MBT_LIM_CACHE;
        idx   = s.dec ? (lim - r.cnt) : r.cnt;
        x     = ((pat == `MBT_PAT_COLM) && !blk[`MBT_BLK_MMU]) ? idx[10:5]
                                                                : idx[5:0];
        y     = ((pat == `MBT_PAT_COLM) && !blk[`MBT_BLK_MMU]) ? idx[4:0]
                                                                : idx[10:6];
        d     = {4{r.instr[`MBT_DW_RNG]}};
        r_nxt = r;
        r_nxt.sync1 = {test_config_select, scan_input_bus, scan_mode_select,
                       test_reset_override, bus_reset_n, soft_reset_n,
                       external_test_mode, internal_test_mode,
                       output_hold_safe, debug_domain_reset_safe,
                       user_logic_wrapper_isolate};
        r_nxt.sync2 = r.sync1;
        r_nxt.areq  = 1'b0;
        r_nxt.awe   = 1'b0;
        r_nxt.uwe   = 1'b0;
        r_nxt.rd_pend = 1'b0;
        if (r.rd_pend && (array_rdata != r.exp)) begin
            r_nxt.err = 1'b1;
        end
        case (cfg)
            `MBT_CFG_LOAD: begin
                r_nxt.st    = mbt_pkg::ST_LOAD;
                r_nxt.instr = r.sync2[`MBT_PIN_SCAN];
                r_nxt.cnt   = '0;
                r_nxt.pass  = '0;
                r_nxt.err   = r.rd_pend && (array_rdata != r.exp);
                r_nxt.done  = 1'b0;
                r_nxt.native = 1'b0;
                r_nxt.rd_pend = 1'b0;
            end
            `MBT_CFG_RUN: begin
                case (r.st)
                    mbt_pkg::ST_LOAD: begin
                        if (ctl == `MBT_CTL_NATIVE) begin
                            r_nxt.st     = mbt_pkg::ST_NATIVE;
                            r_nxt.native = 1'b1;
                        end else if (((ctl != `MBT_CTL_NORMAL) &&
                                      (ctl != `MBT_CTL_STOP)) ||
                                     !f_blk_ok(blk) || (np == 5'h00)) begin
                            r_nxt.st   = mbt_pkg::ST_DONE;
                            r_nxt.done = 1'b1;
                        end else begin
                            r_nxt.st = mbt_pkg::ST_RUN;
                        end
                    end
                    mbt_pkg::ST_RUN: begin
                        if ((ctl == `MBT_CTL_STOP) && r.err) begin
                            r_nxt.st = mbt_pkg::ST_HALT;
                        end else begin
                            r_nxt.areq  = 1'b1;
                            r_nxt.awe   = s.wr;
                            r_nxt.aaddr = blk[`MBT_BLK_MMU] ? {5'h00, x}
                                                            : {y, x};
                            if (s.inv ^ (((pat == `MBT_PAT_WCKB) ||
                                          (pat == `MBT_PAT_RCKB)) &&
                                         (x[0] ^ (y[0] &
                                          ~blk[`MBT_BLK_MMU])))) begin
                                d = ~d;
                            end
                            r_nxt.awdata  = d;
                            r_nxt.rd_pend = ~s.wr;
                            r_nxt.exp     = d;
                            if (r.cnt == lim) begin
                                r_nxt.cnt  = '0;
                                r_nxt.pass = r.pass + 5'h01;
                                if (r.pass + 5'h01 == np) begin
                                    r_nxt.st   = mbt_pkg::ST_DONE;
                                    r_nxt.done = 1'b1;
                                end
                            end else begin
                                r_nxt.cnt = r.cnt + 11'h001;
                            end
                        end
                    end
                    mbt_pkg::ST_DONE: begin
                        if ((ctl == `MBT_CTL_STOP) && r.err) begin
                            r_nxt.st = mbt_pkg::ST_HALT;
                        end
                    end
                    mbt_pkg::ST_HALT,
                    mbt_pkg::ST_NATIVE: r_nxt.st = r.st;
                    default: r_nxt.st = mbt_pkg::ST_IDLE;
                endcase
            end
            `MBT_CFG_ICUL, `MBT_CFG_DCUL, `MBT_CFG_CAMUL: begin
                r_nxt.st    = mbt_pkg::ST_IDLE;
                r_nxt.uwe   = 1'b1;
                r_nxt.udata = r.sync2[`MBT_PIN_SCAN];
                r_nxt.ucam  = (cfg == `MBT_CFG_CAMUL);
                if (cfg == `MBT_CFG_CAMUL) begin
                    r_nxt.utgt = 2'h0;
                end else if (!r.instr[`MBT_DW_SERIAL]) begin
                    r_nxt.utgt = 2'h3;
                end else begin
                    r_nxt.utgt = (cfg == `MBT_CFG_ICUL) ? 2'h1 : 2'h2;
                end
            end
            default: r_nxt.st = mbt_pkg::ST_IDLE;
        endcase
        r_nxt.busy = (r_nxt.st == mbt_pkg::ST_RUN);
        if (fifo_pop) begin
            if (fifo_valid) begin
                r_nxt.sout = fifo_data;
            end
        end else begin
            r_nxt.sout = {r.st, r.err, r.done, r.cnt};
        end
        r_nxt.bus_rn  = r.sync2[`MBT_PIN_BRN] &&
                        !(r.sync2[`MBT_PIN_SMODE] && r.sync2[`MBT_PIN_OVR]) &&
                        !r.sync2[`MBT_PIN_EXT];
        r_nxt.soft_rn = r.sync2[`MBT_PIN_SRN] &&
                        !(r.sync2[`MBT_PIN_SMODE] && r.sync2[`MBT_PIN_OVR]) &&
                        !r.sync2[`MBT_PIN_EXT];
        r_nxt.dbg_rst = (r.sync2[`MBT_PIN_EXT] && r.sync2[`MBT_PIN_RSAFE]) ||
                        (r.sync2[`MBT_PIN_SMODE] && r.sync2[`MBT_PIN_OVR]);
        r_nxt.freeze  = r.sync2[`MBT_PIN_INT] && r.sync2[`MBT_PIN_HOLD];
        r_nxt.short_chain = r.sync2[`MBT_PIN_ISO];
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r         <= '0;
            r.bus_rn  <= 1'b0;
            r.soft_rn <= 1'b0;
        end else begin
            r <= r_nxt;
        end
    end

    assign scan_output_bus     = r.sout;
    assign core_bus_reset_n    = r.bus_rn;
    assign core_soft_reset_n   = r.soft_rn;
    assign debug_domain_reset  = r.dbg_rst;
    assign core_output_freeze  = r.freeze;
    assign wrapper_short_chain = r.short_chain;
    assign array_req           = r.areq;
    assign array_we            = r.awe;
    assign array_block         = r.instr[`MBT_BLK_RNG];
    assign array_addr          = r.aaddr;
    assign array_wdata         = r.awdata;
    assign upload_we           = r.uwe;
    assign upload_target       = r.utgt;
    assign upload_cam          = r.ucam;
    assign upload_data         = r.udata;
    assign bist_busy           = r.busy;
    assign bist_done           = r.done;
    assign bist_error          = r.err;
    assign native_exec         = r.native;

    sequence s_load;
        cfg == `MBT_CFG_LOAD;
    endsequence

    property p_load;
        @(posedge clk_sys) disable iff (sys_rst)
        s_load |=> (r.st == mbt_pkg::ST_LOAD) &&
                   (r.instr == $past(r.sync2[`MBT_PIN_SCAN]));
    endproperty
    a_load: assert property (p_load) else $error("load failed");

    property p_keep;
        @(posedge clk_sys) disable iff (sys_rst)
        (cfg != `MBT_CFG_LOAD) |=> $stable(r.instr);
    endproperty
    a_keep: assert property (p_keep) else $error("instr moved");

    sequence s_err_run;
        (r.st == mbt_pkg::ST_RUN) && r_nxt.err && (ctl == `MBT_CTL_STOP) &&
        (cfg == `MBT_CFG_RUN);
    endsequence

    property p_halt;
        @(posedge clk_sys) disable iff (sys_rst)
        s_err_run ##1 (cfg == `MBT_CFG_RUN) |=> (r.st == mbt_pkg::ST_HALT);
    endproperty
    a_halt: assert property (p_halt) else $error("no halt");

    property p_nohalt;
        @(posedge clk_sys) disable iff (sys_rst)
        (ctl == `MBT_CTL_NORMAL) |-> (r.st != mbt_pkg::ST_HALT);
    endproperty
    a_nohalt: assert property (p_nohalt) else $error("bad halt");

    property p_native;
        @(posedge clk_sys) disable iff (sys_rst)
        (r.st == mbt_pkg::ST_LOAD) && (cfg == `MBT_CFG_RUN) &&
        (ctl == `MBT_CTL_NATIVE) |=> native_exec && !array_req;
    endproperty
    a_native: assert property (p_native) else $error("no native");

    property p_rsvd;
        @(posedge clk_sys) disable iff (sys_rst)
        (r.st == mbt_pkg::ST_LOAD) && (cfg == `MBT_CFG_RUN) &&
        (f_npass(pat) == 5'h00) |=> bist_done && !array_req;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved ran");

    property p_dlout;
        @(posedge clk_sys) disable iff (sys_rst)
        fifo_pop && fifo_valid |=> (scan_output_bus == $past(fifo_data));
    endproperty
    a_dlout: assert property (p_dlout) else $error("dl data lost");

    property p_ovr;
        @(posedge clk_sys) disable iff (sys_rst)
        r.sync2[`MBT_PIN_SMODE] && r.sync2[`MBT_PIN_OVR] |=>
            !core_bus_reset_n && !core_soft_reset_n && debug_domain_reset;
    endproperty
    a_ovr: assert property (p_ovr) else $error("override lost");

    property p_freeze;
        @(posedge clk_sys) disable iff (sys_rst)
        internal_test_mode && output_hold_safe [*3] |=> core_output_freeze;
    endproperty
    a_freeze: assert property (p_freeze) else $error("no freeze");

    property p_ext;
        @(posedge clk_sys) disable iff (sys_rst)
        external_test_mode [*3] |=> !core_bus_reset_n && !core_soft_reset_n;
    endproperty
    a_ext: assert property (p_ext) else $error("core not reset");
endmodule

//--- rtl/mbt_defs.svh
`ifndef MBT_DEFS_SVH
`define MBT_DEFS_SVH
// Test configuration codes
`define MBT_CFG_ICDL     3'h0
`define MBT_CFG_DCDL     3'h1
`define MBT_CFG_ICUL     3'h2
`define MBT_CFG_DCUL     3'h3
`define MBT_CFG_CAMUL    3'h4
`define MBT_CFG_CAMDL    3'h5
`define MBT_CFG_LOAD     3'h6
`define MBT_CFG_RUN      3'h7
// Instruction fields
`define MBT_CTL_RNG      15:12
`define MBT_BLK_RNG      11:8
`define MBT_DW_RNG       7:4
`define MBT_PAT_RNG      3:0
`define MBT_DW_SERIAL    4
// Engine control codes
`define MBT_CTL_NORMAL   4'h0
`define MBT_CTL_STOP     4'h1
`define MBT_CTL_NATIVE   4'hf
// Block codes, bit 3 selects the MMU arrays
`define MBT_BLK_MMU      3
`define MBT_LIM_CACHE    11'h7ff
`define MBT_LIM_MMU      11'h03f
// Pattern codes
`define MBT_PAT_WSOL     4'h0
`define MBT_PAT_RSOL     4'h1
`define MBT_PAT_WCKB     4'h2
`define MBT_PAT_RCKB     4'h3
`define MBT_PAT_ROWM     4'h4
`define MBT_PAT_COLM     4'h5
`define MBT_PAT_BANG18   4'h6
`define MBT_PAT_BANG2    4'hf
`define MBT_N_ONE        5'h01
`define MBT_N_MARCH      5'h06
`define MBT_N_BANG18     5'h12
`define MBT_N_BANG2      5'h02
// Synchronised pin vector layout
`define MBT_PIN_W        28
`define MBT_PIN_CFG      27:25
`define MBT_PIN_SCAN     24:9
`define MBT_PIN_SMODE    8
`define MBT_PIN_OVR      7
`define MBT_PIN_BRN      6
`define MBT_PIN_SRN      5
`define MBT_PIN_EXT      4
`define MBT_PIN_INT      3
`define MBT_PIN_HOLD     2
`define MBT_PIN_RSAFE    1
`define MBT_PIN_ISO      0
`endif

//--- rtl/mbt_pkg.sv
`include "mbt_defs.svh"
package mbt_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_LOAD   = 3'h1,
        ST_RUN    = 3'h3,
        ST_DONE   = 3'h2,
        ST_HALT   = 3'h6,
        ST_NATIVE = 3'h7
    } mbt_state_type;

    typedef struct packed {
        logic wr;
        logic inv;
        logic dec;
    } mbt_step_type;

    typedef struct packed {
        logic [`MBT_PIN_W-1:0] sync1;
        logic [`MBT_PIN_W-1:0] sync2;
        mbt_state_type         st;
        logic [15:0]           instr;
        logic [10:0]           cnt;
        logic [4:0]            pass;
        logic                  rd_pend;
        logic [15:0]           exp;
        logic                  err;
        logic                  done;
        logic [15:0]           sout;
        logic                  areq;
        logic                  awe;
        logic [10:0]           aaddr;
        logic [15:0]           awdata;
        logic                  uwe;
        logic [1:0]            utgt;
        logic                  ucam;
        logic [15:0]           udata;
        logic                  bus_rn;
        logic                  soft_rn;
        logic                  dbg_rst;
        logic                  freeze;
        logic                  short_chain;
        logic                  native;
        logic                  busy;
    } mbt_ctrl_type;
endpackage

//--- test/mbt_mem_model.sv
`timescale 1ns/1ps
module mbt_mem_model (
    // Clock
    input  wire logic        clk_sys,
    // Array port
    input  wire logic        array_req,
    input  wire logic        array_we,
    input  wire logic [10:0] array_addr,
    input  wire logic [15:0] array_wdata,
    output logic [15:0]      array_rdata,
    // Fault injection
    input  wire logic        flip_en
);
    logic [15:0] mem [0:2047];
    initial array_rdata = 16'h5a5a;
    // Answer mid-cycle so data stands at the next rising edge
    always @(negedge clk_sys) begin
        if (array_req && array_we) begin
            mem[array_addr] <= array_wdata;
        end
        if (array_req && !array_we) begin
            array_rdata <= mem[array_addr] ^ {16{flip_en}};
        end else begin
            array_rdata <= ~array_rdata;
        end
    end
endmodule

//--- test/memory_bist_test_port_control_bench.sv
`timescale 1ns/1ps
`include "mbt_defs.svh"
module memory_bist_test_port_control_bench;
    logic        clk_sys, sys_rst, flip_en, dl_valid, dl_ready;
    logic        array_req, array_we, upload_we, upload_cam;
    logic        bist_busy, bist_done, bist_error, native_exec;
    logic        core_bus_reset_n, core_soft_reset_n;
    logic        debug_domain_reset, core_output_freeze;
    logic        wrapper_short_chain;
    logic [1:0]  upload_target;
    logic [2:0]  test_config_select;
    logic [3:0]  array_block;
    logic [8:0]  pv;
    logic [10:0] array_addr;
    logic [15:0] scan_input_bus, scan_output_bus, array_wdata;
    logic [15:0] array_rdata, upload_data, dl_data;
    int          bad_count, samples_checked;

    mbt_ctrl mbt_ctrl_i (
        .clk_sys, .sys_rst, .test_config_select, .scan_input_bus,
        .scan_output_bus, .scan_mode_select(pv[8]),
        .test_reset_override(pv[7]), .bus_reset_n(pv[6]),
        .soft_reset_n(pv[5]), .external_test_mode(pv[4]),
        .internal_test_mode(pv[3]), .output_hold_safe(pv[2]),
        .debug_domain_reset_safe(pv[1]),
        .user_logic_wrapper_isolate(pv[0]), .core_bus_reset_n,
        .core_soft_reset_n, .debug_domain_reset, .core_output_freeze,
        .wrapper_short_chain, .array_req, .array_we, .array_block,
        .array_addr, .array_wdata, .array_rdata, .upload_we,
        .upload_target, .upload_cam, .upload_data, .dl_valid, .dl_data,
        .dl_ready, .bist_busy, .bist_done, .bist_error, .native_exec
    );
    mbt_mem_model mbt_mem_model_i (
        .clk_sys, .array_req, .array_we, .array_addr, .array_wdata,
        .array_rdata, .flip_en
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic cyc(int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic load(logic [15:0] ins);
        test_config_select = `MBT_CFG_LOAD;
        scan_input_bus = ins;
        cyc(5);
    endtask

    task automatic run(logic [15:0] ins, logic fl, int n, logic [2:0] st,
                       logic er);
        int c, k, i;
        logic [10:0] mx;
        load(ins);
        test_config_select = `MBT_CFG_RUN;
        flip_en = fl;
        c = 0;
        k = 0;
        mx = '0;
        for (i = 0; i < 3000 && k < 3; i++) begin
            cyc(1);
            if (i == 3) scan_input_bus = ~ins;
            if (array_req === 1'b1) c++;
            if (array_req === 1'b1 && array_addr > mx) mx = array_addr;
            if (scan_output_bus[15:13] inside {3'h2, 3'h6, 3'h7}) k++;
        end
        if (k < 3) begin
            bad_count++;
            final_report();
        end
        if (n < 0) chk("halt", 1, c < 5);
        else chk("accesses", n, c);
        if (n > 0) chk("addr top", ins[11] ? 16'h003f : 16'h07ff, mx);
        chk("state", st, scan_output_bus[15:13]);
        chk("error", er, bist_error);
        chk("done", st == 3'h2, bist_done);
        chk("native", st == 3'h7, native_exec);
        chk("block", ins[11:8], array_block);
        flip_en = 1'b0;
    endtask

    task automatic t_wrapper();
        logic [8:0] cs [7] = '{9'h060, 9'h1e0, 9'h020, 9'h072,
                               9'h06d, 9'h070, 9'h064};
        logic       sm, ov, ex;
        foreach (cs[j]) begin
            pv = cs[j];
            cyc(4);
            {sm, ov, ex} = {pv[8], pv[7], pv[4]};
            chk("bus rst", pv[6] & !(sm & ov) & !ex, core_bus_reset_n);
            chk("soft rst", pv[5] & !(sm & ov) & !ex, core_soft_reset_n);
            chk("dbg rst", (ex & pv[1]) | (sm & ov), debug_domain_reset);
            chk("freeze", pv[3] & pv[2], core_output_freeze);
            chk("short", pv[0], wrapper_short_chain);
        end
        pv = 9'h060;
    endtask

    task automatic t_patterns();
        logic [3:0] pat [8] = '{4'h0, 4'h1, 4'h2, 4'h3,
                                4'h4, 4'h5, 4'h6, 4'hf};
        int         nn [8] = '{1, 1, 1, 1, 6, 6, 18, 2};
        foreach (pat[j]) run({8'h08, 4'h5, pat[j]}, 0, nn[j] * 64, 3'h2, 0);
        run(16'h0150, 0, 2048, 3'h2, 0);
        run(16'h0a50, 0, 64, 3'h2, 0);
    endtask

    task automatic t_reserved();
        run(16'h0857, 0, 0, 3'h2, 0);
        run(16'h5850, 0, 0, 3'h2, 0);
        run(16'h0450, 0, 0, 3'h2, 0);
        run(16'hf850, 0, 0, 3'h7, 0);
    endtask

    task automatic t_errors();
        run(16'h0850, 0, 64, 3'h2, 0);
        run(16'h0831, 0, 64, 3'h2, 1);
        run(16'h0851, 1, 64, 3'h2, 1);
        run(16'h1851, 1, -1, 3'h6, 1);
    endtask

    task automatic t_upload();
        logic [6:0] uc [4] = '{7'h51, 7'h5a, 7'h13, 7'h64};
        pv = 9'h1e0;
        cyc(4);
        pv = 9'h060;
        foreach (uc[j]) begin
            load({8'h18, 3'h0, uc[j][6], 4'h0});
            test_config_select = uc[j][5:3];
            cyc(3);
            scan_input_bus = 16'h9c30 + 16'(j);
            cyc(4);
            chk("up we", 1, upload_we);
            chk("up data", 16'h9c30 + 16'(j), upload_data);
            chk("up tgt", uc[j][1:0], upload_target);
            chk("up cam", uc[j][2], upload_cam);
        end
    endtask

    task automatic t_download(logic [2:0] cfg);
        int          n, k, i;
        logic        acc;
        logic [15:0] w [5];
        for (i = 0; i < 5; i++) w[i] = 16'h1b00 + 16'(cfg * 16 + i);
        test_config_select = `MBT_CFG_LOAD;
        cyc(4);
        n = 0;
        for (i = 0; i < 10 && n < 5; i++) begin
            cyc(1);
            dl_data = w[n];
            dl_valid = 1'b1;
            if (dl_ready === 1'b1) n++;
            else break;
        end
        chk("fill", 4, n);
        test_config_select = cfg;
        k = 0;
        acc = 1'b0;
        for (i = 0; i < 30; i++) begin
            cyc(1);
            if (acc) dl_valid = 1'b0;
            acc = dl_valid && dl_ready;
            if (k < 5 && scan_output_bus === w[k]) k++;
        end
        chk("drain", 5, k);
        chk("ready", 1, dl_ready);
    endtask

    initial begin
        sys_rst = 1'b1;
        flip_en = 1'b0;
        dl_valid = 1'b0;
        dl_data = 16'h0;
        pv = 9'h060;
        test_config_select = `MBT_CFG_LOAD;
        scan_input_bus = 16'h0;
        bad_count = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("rst out", 16'h0, scan_output_bus);
        chk("rst rdy", 1, dl_ready);
        t_wrapper();
        t_patterns();
        t_reserved();
        t_errors();
        t_upload();
        t_download(`MBT_CFG_ICDL);
        t_download(`MBT_CFG_DCDL);
        t_download(`MBT_CFG_CAMDL);
        final_report();
    end
endmodule
